// file: host_port_device.sv
// Functional notes
// - Active-low link, 16 data plus six controls
// - Write strobe loads command or output data
// - Host never asserts read and write together
// - Read drives status or input data register
// - Select picks command/status versus data registers
// - Host waits for ready before data transfers
// - Status read works while not ready
// - Service request when enabled interrupt bit set
// - Service request held until status read or, for done, a data access
// - Done set on ready rise, cleared on data access or status read
// - Master clear resets registers and whole system
// - Strobe edges synchronised to system clock
// - Writes act on strobe leading edge only
// - Read data stable for whole strobe
// - Host holds select through read plus 250 ns
// - Ready drops after data and update transfers
// - Data read starts internal refill read
// - Command write without reset bit gives one-cycle load pulse
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
			$error("word_fifo DEPTH must be a power of two, at least 2");
		end
	endgenerate
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;
	assign in_ready = count_reg != (AW+1)'(DEPTH);
	assign out_valid = count_reg != '0;
	assign out_data = mem[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge CLK) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule

module host_port_device (
	input wire logic CLK,
	input wire logic RST_N,
	host_link_if.device LINK,
	output logic [15:0] XB_WR_DATA,
	output logic XB_WR_VALID,
	input wire logic XB_WR_READY,
	output logic XB_RD_REQ,
	input wire logic [15:0] XB_RD_DATA,
	input wire logic XB_RD_VALID,
	output logic [2:0] XB_DEV_SEL,
	output logic XB_CMD_LOAD,
	input wire logic IRQ_XMT,
	input wire logic IRQ_RCV,
	input wire logic IRQ_ILL,
	input wire logic IRQ_CRS,
	output logic SYS_RESET
);
	localparam logic [7:0] XFER_LOAD = 8'(host_port_pkg::XFER_CYC);
	localparam logic [7:0] CLR_LOAD = 8'(host_port_pkg::CLR_CYC);
	// Synchroniser stages, order {clr, cmd, read, write}
	logic [3:0] s1_reg;
	logic [3:0] s2_reg;
	logic [3:0] s3_reg;
	logic [4:0] en_reg;
	logic [2:0] dsel_reg;
	logic cmd_load_reg;
	logic [7:0] rst_cnt_reg;
	logic sysrst_reg;
	logic [7:0] busy_cnt_reg;
	logic rd_pend_reg;
	logic rd_req_reg;
	logic [15:0] in_data_reg;
	logic rdy_n_reg;
	logic [4:0] irq_reg;
	logic int_n_reg;
	logic [15:0] out_n_reg;
	logic oe_reg;
	logic rd_cmd_reg;
	logic wr_lead, rd_lead, rd_trail, cmd_sel, mclr;
	logic wr_cmd, wr_data, prog_rst, clr_all, start_rd, ready_now, done_set;
	logic fifo_in_ready;
	logic [15:0] host_word;
	logic [4:0] irq_clr;
	logic [4:0] irq_mask;

	function automatic logic [15:0] status_word(input logic [2:0] dsel, input logic [4:0] en,
			input logic rdy, input logic [4:0] irq);
		logic [15:0] w;
		w = 16'h0000;
		w[host_port_pkg::ST_DSEL_LO +: 3] = dsel;
		// Command order is {RDY_E, XMT_E, RCV_E, MIX_E, PRE}; status puts PRE on top
		w[host_port_pkg::ST_EN_LO +: 5] = {en[0], en[4:1]};
		w[host_port_pkg::ST_RDY] = rdy;
		w[host_port_pkg::ST_DONE] = irq[4];
		w[host_port_pkg::ST_XMT] = irq[3];
		w[host_port_pkg::ST_RCV] = irq[2];
		w[host_port_pkg::ST_ILL] = irq[1];
		w[host_port_pkg::ST_CRS] = irq[0];
		return w;
	endfunction

	// Lines are active low; invert on entry
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= {~LINK.clr_n, ~LINK.cmd_n, ~LINK.read_n, ~LINK.write_n};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	assign host_word = ~LINK.data_n;
	assign wr_lead = s2_reg[0] && !s3_reg[0];
	assign rd_lead = s2_reg[1] && !s3_reg[1];
	assign rd_trail = !s2_reg[1] && s3_reg[1];
	assign cmd_sel = s2_reg[2];
	assign mclr = s2_reg[3];
	assign wr_cmd = wr_lead && cmd_sel;
	assign wr_data = wr_lead && !cmd_sel;
	assign prog_rst = wr_cmd && host_word[host_port_pkg::CMD_RESET];
	assign clr_all = !RST_N || mclr || prog_rst;
	assign start_rd = (rd_trail && !rd_cmd_reg) ||
		(wr_cmd && !prog_rst && host_word[host_port_pkg::CMD_PRE]);
	assign ready_now = busy_cnt_reg == 8'h00 && !rd_pend_reg && fifo_in_ready &&
		!sysrst_reg && rst_cnt_reg == 8'h00;
	assign done_set = ready_now && rdy_n_reg;
	assign irq_clr = {(rd_lead && !cmd_sel) || wr_data, 4'h0} |
		{5{rd_trail && rd_cmd_reg}};
	assign irq_mask = {en_reg[4:1], en_reg[1]};

	// Command register
	always_ff @(posedge CLK) begin
		if (clr_all) begin
			en_reg <= '0;
			dsel_reg <= '0;
			cmd_load_reg <= 1'b0;
		end else begin
			cmd_load_reg <= wr_cmd;
			if (wr_cmd) begin
				en_reg <= host_word[host_port_pkg::CMD_EN_HI:host_port_pkg::CMD_EN_LO];
				if (host_word[host_port_pkg::CMD_SEL_EN]) begin
					dsel_reg <= host_word[host_port_pkg::CMD_DSEL_HI:host_port_pkg::CMD_DSEL_LO];
				end
			end
		end
	end

	// System reset stretch
	always_ff @(posedge CLK) begin
		if (clr_all) begin
			rst_cnt_reg <= CLR_LOAD;
			sysrst_reg <= 1'b1;
		end else begin
			if (rst_cnt_reg != 8'h00) begin
				rst_cnt_reg <= rst_cnt_reg - 8'h01;
			end
			sysrst_reg <= rst_cnt_reg != 8'h00;
		end
	end

	// Internal transfer tracking
	always_ff @(posedge CLK) begin
		if (clr_all) begin
			busy_cnt_reg <= 8'h00;
			rd_pend_reg <= 1'b0;
			rd_req_reg <= 1'b0;
			in_data_reg <= 16'h0000;
		end else begin
			rd_req_reg <= start_rd;
			if (wr_data || start_rd) begin
				busy_cnt_reg <= XFER_LOAD;
			end else if (busy_cnt_reg != 8'h00) begin
				busy_cnt_reg <= busy_cnt_reg - 8'h01;
			end
			if (start_rd) begin
				rd_pend_reg <= 1'b1;
			end else if (XB_RD_VALID) begin
				rd_pend_reg <= 1'b0;
			end
			if (rd_pend_reg && XB_RD_VALID) begin
				in_data_reg <= XB_RD_DATA;
			end
		end
	end

	// Ready and interrupts
	always_ff @(posedge CLK) begin
		if (clr_all) begin
			rdy_n_reg <= 1'b1;
			irq_reg <= '0;
			int_n_reg <= 1'b1;
		end else begin
			rdy_n_reg <= !ready_now;
			// A new event beats a clear in the same cycle
			irq_reg <= (irq_reg & ~irq_clr) | {done_set, IRQ_XMT, IRQ_RCV, IRQ_ILL, IRQ_CRS};
			int_n_reg <= !(|(irq_reg & irq_mask));
		end
	end

	// Read drivers, word latched for the whole strobe
	always_ff @(posedge CLK) begin
		if (!RST_N || mclr) begin
			out_n_reg <= 16'hffff;
			oe_reg <= 1'b0;
			rd_cmd_reg <= 1'b0;
		end else if (rd_lead) begin
			oe_reg <= 1'b1;
			rd_cmd_reg <= cmd_sel;
			out_n_reg <= ~(cmd_sel ? status_word(dsel_reg, en_reg, !rdy_n_reg, irq_reg)
				: in_data_reg);
		end else if (rd_trail) begin
			oe_reg <= 1'b0;
		end
	end

	word_fifo #(.WIDTH(host_port_pkg::DATA_W), .DEPTH(host_port_pkg::FIFO_DEPTH)) u_fifo (
		.CLK(CLK),
		.RST_N(RST_N && !mclr && !prog_rst),
		.in_valid(wr_data),
		.in_ready(fifo_in_ready),
		.in_data(host_word),
		.out_valid(XB_WR_VALID),
		.out_ready(XB_WR_READY),
		.out_data(XB_WR_DATA)
	);

	assign LINK.dev_data_n = out_n_reg;
	assign LINK.dev_oe = oe_reg;
	assign LINK.ready_n = rdy_n_reg;
	assign LINK.int_n = int_n_reg;
	assign XB_RD_REQ = rd_req_reg;
	assign XB_DEV_SEL = dsel_reg;
	assign XB_CMD_LOAD = cmd_load_reg;
	assign SYS_RESET = sysrst_reg;
endmodule

// file: host_port_pkg.sv
package host_port_pkg;
	localparam int DATA_W = 16;
	localparam int CLK_NS = 4;
	// Host-side timing, in ns
	localparam int SETUP_NS = 100;
	localparam int STROBE_NS = 300;
	localparam int CMD_HOLD_NS = 250;
	localparam int CLR_NS = 500;
	// Internal transfer interval, in ns
	localparam int XFER_NS = 450;
	// Least times round up to whole cycles
	localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_CYC = (CMD_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int CLR_CYC = (CLR_NS + CLK_NS - 1) / CLK_NS;
	localparam int XFER_CYC = (XFER_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 8;
	// Command word fields
	localparam int CMD_RESET = 15;
	localparam int CMD_EN_HI = 14;
	localparam int CMD_EN_LO = 10;
	localparam int CMD_PRE = 10;
	localparam int CMD_SEL_EN = 9;
	localparam int CMD_DSEL_HI = 8;
	localparam int CMD_DSEL_LO = 6;
	// Status word fields
	localparam int ST_DSEL_LO = 13;
	localparam int ST_EN_LO = 8;
	localparam int ST_RDY = 6;
	localparam int ST_XMT = 5;
	localparam int ST_RCV = 4;
	localparam int ST_DONE = 2;
	localparam int ST_ILL = 1;
	localparam int ST_CRS = 0;
	// Sticky interrupt bit order: {done, xmt, rcv, ill, crs}
	localparam int IRQ_N = 5;
	localparam int FIFO_DEPTH = 16;
endpackage

// file: host_link_if.sv
`timescale 1ns/1ps
interface host_link_if;
	logic [15:0] host_data_n;
	logic host_oe;
	logic [15:0] dev_data_n;
	logic dev_oe;
	logic [15:0] data_n;
	logic write_n;
	logic read_n;
	logic cmd_n;
	logic clr_n;
	logic ready_n;
	logic int_n;
	// Terminated lines idle high (inactive)
	assign data_n = dev_oe ? dev_data_n : (host_oe ? host_data_n : 16'hffff);
	modport device(input data_n, input write_n, input read_n, input cmd_n, input clr_n,
		output dev_data_n, output dev_oe, output ready_n, output int_n);
	modport host(input data_n, input ready_n, input int_n, output host_data_n,
		output host_oe, output write_n, output read_n, output cmd_n, output clr_n);
endinterface

// file: host_port_host.sv
`timescale 1ns/1ps
module host_port_host (
	input wire logic CLK,
	input wire logic RST_N,
	host_link_if.host LINK,
	input wire logic REQ_VALID,
	input wire logic REQ_WRITE,
	input wire logic REQ_CMD,
	input wire logic [15:0] REQ_DATA,
	output logic REQ_READY,
	output logic RESP_VALID,
	output logic [15:0] RESP_DATA,
	input wire logic CLEAR_REQ,
	output logic IRQ,
	output logic DEV_READY
);
	typedef enum logic [2:0] {IDLE, SETUP, STROBE, GAP, CLEAR} state_t;
	localparam int CW = host_port_pkg::CNT_W;
	state_t state_reg;
	logic [CW-1:0] cnt_reg;
	logic write_reg;
	logic req_ready_reg;
	logic resp_valid_reg;
	logic [15:0] resp_data_reg;
	logic [15:0] data_n_reg;
	logic oe_reg;
	logic wr_n_reg, rd_n_reg, cmd_n_reg, clr_n_reg;
	logic irq_reg, dev_ready_reg;
	logic may_start;

	// Status reads are allowed while busy
	assign may_start = dev_ready_reg || (!REQ_WRITE && REQ_CMD);

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			irq_reg <= 1'b0;
			dev_ready_reg <= 1'b0;
		end else begin
			irq_reg <= !LINK.int_n;
			dev_ready_reg <= !LINK.ready_n;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state_reg <= IDLE;
			cnt_reg <= '0;
			write_reg <= 1'b0;
			req_ready_reg <= 1'b0;
			resp_valid_reg <= 1'b0;
			resp_data_reg <= 16'h0000;
			data_n_reg <= 16'hffff;
			oe_reg <= 1'b0;
			wr_n_reg <= 1'b1;
			rd_n_reg <= 1'b1;
			cmd_n_reg <= 1'b1;
			clr_n_reg <= 1'b1;
		end else begin
			resp_valid_reg <= 1'b0;
			if (cnt_reg != '0) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
			unique case (state_reg)
				IDLE: begin
					req_ready_reg <= 1'b1;
					if (CLEAR_REQ) begin
						req_ready_reg <= 1'b0;
						clr_n_reg <= 1'b0;
						cnt_reg <= CW'(host_port_pkg::CLR_CYC);
						state_reg <= CLEAR;
					end else if (REQ_VALID && req_ready_reg && may_start) begin
						req_ready_reg <= 1'b0;
						write_reg <= REQ_WRITE;
						cmd_n_reg <= !REQ_CMD;
						data_n_reg <= ~REQ_DATA;
						oe_reg <= REQ_WRITE;
						cnt_reg <= CW'(host_port_pkg::SETUP_CYC);
						state_reg <= SETUP;
					end
				end
				SETUP: begin
					if (cnt_reg == '0) begin
						wr_n_reg <= !write_reg;
						rd_n_reg <= write_reg;
						cnt_reg <= CW'(host_port_pkg::STROBE_CYC);
						state_reg <= STROBE;
					end
				end
				STROBE: begin
					if (cnt_reg == '0) begin
						if (!write_reg) begin
							resp_data_reg <= ~LINK.data_n;
							resp_valid_reg <= 1'b1;
						end
						wr_n_reg <= 1'b1;
						rd_n_reg <= 1'b1;
						oe_reg <= 1'b0;
						cnt_reg <= CW'(host_port_pkg::GAP_CYC);
						state_reg <= GAP;
					end
				end
				GAP: begin
					// Select left unchanged after the strobe
					if (cnt_reg == '0) begin
						state_reg <= IDLE;
					end
				end
				CLEAR: begin
					if (cnt_reg == '0) begin
						clr_n_reg <= 1'b1;
						cnt_reg <= CW'(host_port_pkg::GAP_CYC);
						state_reg <= GAP;
					end
				end
			endcase
		end
	end

	assign LINK.host_data_n = data_n_reg;
	assign LINK.host_oe = oe_reg;
	assign LINK.write_n = wr_n_reg;
	assign LINK.read_n = rd_n_reg;
	assign LINK.cmd_n = cmd_n_reg;
	assign LINK.clr_n = clr_n_reg;
	assign REQ_READY = req_ready_reg;
	assign RESP_VALID = resp_valid_reg;
	assign RESP_DATA = resp_data_reg;
	assign IRQ = irq_reg;
	assign DEV_READY = dev_ready_reg;
endmodule

// file: host_port_props.sv
`timescale 1ns/1ps
module host_port_props (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [15:0] data_n,
	input wire logic [15:0] dev_data_n,
	input wire logic dev_oe,
	input wire logic write_n,
	input wire logic read_n,
	input wire logic cmd_n,
	input wire logic clr_n,
	input wire logic ready_n,
	input wire logic int_n
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	sequence read_start_s;
		$fell(read_n);
	endsequence
	sequence status_end_s;
		$rose(read_n) && !cmd_n;
	endsequence
	sequence data_start_s;
		($fell(read_n) || $fell(write_n)) && cmd_n;
	endsequence
	rw_exclusive_a: assert property (read_n || write_n)
		else $error("read and write strobes overlap");
	read_drive_a: assert property (read_start_s |-> ##4 dev_oe)
		else $error("bus not driven after read start");
	drive_release_a: assert property (dev_oe |-> !$past(read_n, 3))
		else $error("bus driven without a read");
	read_stable_a: assert property (dev_oe && $past(dev_oe) |-> $stable(dev_data_n))
		else $error("read word changed during strobe");
	ready_wait_a: assert property (data_start_s |-> !ready_n)
		else $error("data transfer started while busy");
	write_busy_a: assert property ($fell(write_n) && cmd_n |-> ##[4:5] ready_n)
		else $error("ready kept after data write");
	select_hold_a: assert property ($rose(read_n) |-> $stable(cmd_n) [*8])
		else $error("select moved after read");
	int_clear_a: assert property (status_end_s |-> ##5 int_n)
		else $error("service request kept after status read");
	clear_busy_a: assert property ($fell(clr_n) |-> ##[1:6] ready_n)
		else $error("ready kept during master clear");
endmodule

// file: host_parallel_interface_port_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
	$display("BAD %0t got %h exp %h", $time, a, b); end end
module host_parallel_interface_port_bench;
	logic clk = 0, rst_n = 0, rq_v = 0, rq_w = 0, rq_c = 0, clr = 0, wr_rdy = 0, rd_v = 0;
	logic [15:0] rq_d = 0, rd_d = 0, rsp_d, wr_d, last_wire, word, st;
	logic rq_rdy, rsp_v, irq, dev_rdy, rd_req, cmd_ld, sys_rst, wr_v, drain = 1;
	logic [3:0] ev = 0;
	logic [2:0] dsel, dev_sel;
	logic [15:0] expq[$], gotq[$], rdq[$], rw[2];
	int bad_count = 0, compares = 0, cycles = 0, seed = 86757, loads = 0;
	host_link_if link();
	host_port_host host_port_host_i(.CLK(clk), .RST_N(rst_n), .LINK(link), .REQ_VALID(rq_v),
		.REQ_WRITE(rq_w), .REQ_CMD(rq_c), .REQ_DATA(rq_d), .REQ_READY(rq_rdy),
		.RESP_VALID(rsp_v), .RESP_DATA(rsp_d), .CLEAR_REQ(clr), .IRQ(irq), .DEV_READY(dev_rdy));
	host_port_device host_port_device_i(.CLK(clk), .RST_N(rst_n), .LINK(link),
		.XB_WR_DATA(wr_d), .XB_WR_VALID(wr_v), .XB_WR_READY(wr_rdy), .XB_RD_REQ(rd_req),
		.XB_RD_DATA(rd_d), .XB_RD_VALID(rd_v), .XB_DEV_SEL(dev_sel), .XB_CMD_LOAD(cmd_ld),
		.IRQ_XMT(ev[3]), .IRQ_RCV(ev[2]), .IRQ_ILL(ev[1]), .IRQ_CRS(ev[0]), .SYS_RESET(sys_rst));
	host_port_props host_port_props_i(.CLK(clk), .RST_N(rst_n), .data_n(link.data_n),
		.dev_data_n(link.dev_data_n), .dev_oe(link.dev_oe), .write_n(link.write_n),
		.read_n(link.read_n), .cmd_n(link.cmd_n), .clr_n(link.clr_n), .ready_n(link.ready_n),
		.int_n(link.int_n));
	always #2 clk = ~clk;
	task automatic results();
		$display("Comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cmd_ld === 1'b1) loads++;
		if (wr_v === 1'b1 && wr_rdy === 1'b1) gotq.push_back(wr_d);
		if (link.write_n === 1'b0) last_wire = link.data_n;
		#1 wr_rdy <= drain & 1'($random(seed));
		if (cycles == 20000) begin
			bad_count++;
			results();
		end
	end
	// Internal side answers a refill request three cycles later
	always @(posedge clk) if (rd_req === 1'b1) begin
		repeat (3) @(posedge clk);
		#1 rd_v <= 1;
		rd_d <= rdq.pop_front();
		@(posedge clk);
		#1 rd_v <= 0;
		rd_d <= ~rd_d;
	end
	task automatic req(input logic w, input logic c, input logic [15:0] d);
		@(posedge clk);
		#1 rq_v <= 1;
		rq_w <= w;
		rq_c <= c;
		rq_d <= d;
		do @(posedge clk); while (rq_rdy !== 1'b0);
		#1 rq_v <= 0;
		while (rq_rdy !== 1'b1) begin
			@(posedge clk);
			if (rsp_v === 1'b1) st = rsp_d;
		end
	endtask
	task automatic wait_rdy();
		while (dev_rdy !== 1'b1) @(posedge clk);
	endtask
	task automatic pulse(input logic [3:0] e);
		#1 ev <= e;
		@(posedge clk);
		#1 ev <= 4'h0;
		repeat (4) @(posedge clk);
	endtask
	function automatic logic [15:0] cw(logic rdy_e, logic [2:0] en, logic pre, logic sel,
		logic [2:0] ds);
		return {1'b0, rdy_e, en, pre, sel, ds, 6'h00};
	endfunction
	initial begin
		repeat (12) @(posedge clk);
		#1 rst_n <= 1;
		wait_rdy();
		`CHK(sys_rst, 1'b0)
		// Non-zero so that the clear visibly resets the select
		dsel = 3'($random(seed)) | 3'h4;
		loads = 0;
		req(1, 1, cw(1, 3'h0, 0, 1, dsel));
		`CHK(loads, 1)
		`CHK(dev_sel, dsel)
		req(1, 1, cw(1, 3'h0, 0, 0, ~dsel));
		`CHK(dev_sel, dsel)
		word = $random(seed);
		expq.push_back(word);
		req(1, 0, word);
		`CHK(last_wire, ~word)
		wait_rdy();
		repeat (4) @(posedge clk);
		`CHK(irq, 1'b1)
		req(0, 1, 16'h0000);
		`CHK(st[15:8], {dsel, 5'b01000})
		`CHK({st[6], st[2]}, 2'b11)
		repeat (8) @(posedge clk);
		`CHK(irq, 1'b0)
		req(1, 1, cw(0, 3'b010, 0, 0, 3'h0));
		pulse(4'hb);
		`CHK(irq, 1'b0)
		pulse(4'h4);
		`CHK(irq, 1'b1)
		req(0, 1, 16'h0000);
		`CHK({st[5:4], st[1:0]}, 4'hf)
		repeat (8) @(posedge clk);
		`CHK(irq, 1'b0)
		// Far side stalls while the buffer fills
		drain = 0;
		for (int i = 0; i < 16; i++) begin
			word = $random(seed);
			expq.push_back(word);
			req(1, 0, word);
		end
		repeat (200) @(posedge clk);
		`CHK(dev_rdy, 1'b0)
		req(0, 1, 16'h0000);
		`CHK(st[6], 1'b0)
		drain = 1;
		wait_rdy();
		while (wr_v !== 1'b0) @(posedge clk);
		`CHK(gotq.size(), expq.size())
		foreach (expq[i]) `CHK(gotq[i], expq[i])
		rw[0] = $random(seed);
		rw[1] = $random(seed);
		rdq = '{rw[0], rw[1], 16'h5a5a};
		req(1, 1, cw(0, 3'h0, 1, 0, 3'h0));
		foreach (rw[i]) begin
			req(0, 0, 16'h0000);
			`CHK(st, rw[i])
		end
		#1 clr <= 1;
		while (sys_rst !== 1'b1) @(posedge clk);
		#1 clr <= 0;
		wait_rdy();
		`CHK(dev_sel, 3'h0)
		req(0, 1, 16'h0000);
		`CHK(st[15:8], 8'h00)
		results();
	end
endmodule
